// ===== rpi_frame_timer.sv
// Step and frame timer for the PWM frame: 40 steps per frame.
`timescale 1ns/1ps
`include "rpi_params.svh"

module rpi_frame_timer #(
	parameter int unsigned STEP_CYCLES = `RPI_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	output logic [5:0] step_idx,
	output logic frame_start
);

	logic [31:0] cyc_cnt;
	logic [31:0] next_cyc_cnt;
	logic [5:0] next_step_idx;
	logic next_frame_start;

	// Cycle counter inside a step, step index inside a frame
	always_comb
	begin
		next_cyc_cnt = cyc_cnt + 32'h0000_0001;
		next_step_idx = step_idx;
		next_frame_start = 1'b0;
		if (cyc_cnt >= STEP_CYCLES - 1)
		begin
			next_cyc_cnt = 32'h0000_0000;
			if (step_idx == `RPI_STEPS - 6'h01) // Frame of 40 equal steps
			begin
				next_step_idx = 6'h00;
				next_frame_start = 1'b1;
			end
			else
				next_step_idx = step_idx + 6'h01;
		end
	end

	// Registers only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cyc_cnt <= 32'h0000_0000;
			step_idx <= 6'h00;
			frame_start <= 1'b0;
		end
		else
		begin
			cyc_cnt <= next_cyc_cnt;
			step_idx <= next_step_idx;
			frame_start <= next_frame_start;
		end
	end

endmodule // rpi_frame_timer

// ===== rpi_params.svh
// Constants for the signal-strength PWM indicator: command codes, limits, timing.
`ifndef RPI_PARAMS_SVH
`define RPI_PARAMS_SVH

// Command interface
`define RPI_CODE_HOLD 8'h22
`define RPI_HOLD_RESET 8'h00
`define RPI_HOLD_MAX 8'h7F
`define RPI_HOLD_FOREVER 8'hFF

// Frame layout
`define RPI_STEPS 6'h28
`define RPI_DUTY_MAX 6'h26

// Margin to duty mapping: base + margin * 3 / 5, saturating at the top step
`define RPI_DUTY_BASE 7'h0D
`define RPI_MARGIN_SAT 8'h2A

// Times in their own units and the cycle counts derived from them
`define RPI_CLK_NS 50
`define RPI_STEP_NS 208000
`define RPI_FRAME_NS 8320000
`define RPI_TICK_MS 100
`define RPI_SETTLE_NS 1000
`define RPI_STEP_CYCLES (`RPI_STEP_NS / `RPI_CLK_NS)
`define RPI_TICK_CYCLES ((`RPI_TICK_MS * 1000000) / `RPI_CLK_NS)
`define RPI_SETTLE_CYCLES ((`RPI_SETTLE_NS + `RPI_CLK_NS - 1) / `RPI_CLK_NS)

`endif

// ===== rpi_pin_model.sv
// Board side of the shared mode pin: pull-up plus an optional low strap.
`timescale 1ns/1ps

module rpi_pin_model (
	input logic strap_low,
	input logic pin_out,
	input logic pin_oe,
	output logic pin_level
);
	// Strap only acts while the device leaves the pin as input
	// Pull-up gives a firm level at the power-up sample
	assign pin_level = pin_oe ? pin_out : !strap_low;
endmodule // rpi_pin_model

// ===== rpi_pkg.sv
// Types shared by the signal-strength PWM indicator files.
package rpi_pkg;

	// Power-up and pin ownership states, Gray coded along settle, window, drive
	typedef enum logic [1:0] {
		RPI_SETTLE = 2'b00,
		RPI_WINDOW = 2'b01,
		RPI_DRIVE = 2'b11,
		RPI_IDLE = 2'b10
	} rpi_state_t;

	// Command request from the host-side command decoder
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [7:0] wdata;
	} rpi_cmd_req_t;

	// Command answer
	typedef struct packed {
		logic ack;
		logic err;
		logic [7:0] rdata;
	} rpi_cmd_rsp_t;

	// Multipurpose pin drive as two signals: level and output enable
	typedef struct packed {
		logic out;
		logic oe;
	} rpi_pin_drv_t;

endpackage

// ===== rpi_top.sv
// Signal-strength PWM indicator: hold-time setting, duty mapping, pin sharing.
//
// Behaviour
// - Hold-time setting 0 to 0x7F in 100 ms steps; 0 default, output disabled.
// - Setting is written and read through binary command code 0x22.
// - Enabled PWM drives the shared mode pin, duty tracks margin above sensitivity.
// - High time limited to 0..95 percent; 0 percent means at or below sensitivity.
// - Frame period 8.32 ms made of 40 steps of 0.208 ms.
// - 10 dB gives 47.5, 20 dB 62.5, 30 dB 77.5 percent high time.
// - Nonzero setting shows last packet level for the hold time after it.
// - Hold expiry forces output low; next packet resumes PWM.
// - After power-up output stays low until a packet arrives.
// - Setting 0xFF keeps output enabled permanently, never timing out.
// - Pin is an input at power-up and is sampled for command mode.
// - After the input window, nonzero setting turns pin into output driven low.
// - Nonzero setting keeps pin an input for the setting's period after power-up.
`timescale 1ns/1ps
`include "rpi_params.svh"

module rpi_top #(
	parameter int unsigned STEP_CYCLES = `RPI_STEP_CYCLES,
	parameter int unsigned TICK_CYCLES = `RPI_TICK_CYCLES
) (
	input wire logic CLK,
	input wire logic RST,
	input wire rpi_pkg::rpi_cmd_req_t CMD_REQ,
	output rpi_pkg::rpi_cmd_rsp_t CMD_RSP,
	input wire logic PKT_VALID,
	input wire logic [7:0] PKT_MARGIN,
	input wire logic CFG_PIN_IN,
	output logic CFG_PIN_OUT,
	output logic CFG_PIN_OE,
	output logic CMD_MODE_SEL,
	output logic SAMPLE_DONE
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Accepted setting values: the plain range plus the permanent code
	function automatic logic hold_ok(input logic [7:0] v);
		hold_ok = (v <= `RPI_HOLD_MAX) || (v == `RPI_HOLD_FOREVER);
	endfunction

	// Margin in dB to whole duty steps; linear through the three calibration points
	function automatic logic [5:0] duty_map(input logic [7:0] margin);
		logic [6:0] m7;
		logic [6:0] scaled;
		m7 = margin[6:0];
		scaled = 7'h00;
		if (margin == 8'h00)
			duty_map = 6'h00; // At or below sensitivity
		else if (margin >= `RPI_MARGIN_SAT)
			duty_map = `RPI_DUTY_MAX; // 38 of 40 steps is 95 percent
		else
		begin
			scaled = 7'((m7 * 7'h03) / 7'h05);
			duty_map = 6'(`RPI_DUTY_BASE + scaled); // 10/20/30 dB -> 19/25/31
		end
	endfunction

	// ----------------------------------------------------------------
	// Command interface
	// ----------------------------------------------------------------

	logic [7:0] hold_setting;
	logic [7:0] next_hold_setting;
	rpi_pkg::rpi_cmd_rsp_t rsp;
	rpi_pkg::rpi_cmd_rsp_t next_rsp;

	// Decode one request per cycle; out-of-range writes are refused, not clipped
	always_comb
	begin
		next_hold_setting = hold_setting;
		next_rsp = '0;
		if (CMD_REQ.valid)
		begin
			next_rsp.ack = 1'b1;
			if (CMD_REQ.code != `RPI_CODE_HOLD) // Only the hold-time code lives here
				next_rsp.err = 1'b1;
			else if (CMD_REQ.write)
			begin
				if (hold_ok(CMD_REQ.wdata))
					next_hold_setting = CMD_REQ.wdata;
				else
					next_rsp.err = 1'b1;
			end
			else
				next_rsp.rdata = hold_setting;
		end
	end

	// Setting resets to disabled
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			hold_setting <= `RPI_HOLD_RESET;
			rsp <= '0;
		end
		else
		begin
			hold_setting <= next_hold_setting;
			rsp <= next_rsp;
		end
	end

	assign CMD_RSP = rsp;

	// ----------------------------------------------------------------
	// 100 ms tick
	// ----------------------------------------------------------------

	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic tick;
	logic tick_restart;

	// Restarting on a packet makes the hold time start at the packet, not up to
	// 100 ms earlier; the price is that a packet also stretches the input window
	always_comb
	begin
		tick = (tick_cnt >= TICK_CYCLES - 1);
		if (tick_restart || tick)
			next_tick_cnt = 32'h0000_0000;
		else
			next_tick_cnt = tick_cnt + 32'h0000_0001;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			tick_cnt <= 32'h0000_0000;
		else
			tick_cnt <= next_tick_cnt;
	end

	// ----------------------------------------------------------------
	// Power-up sequence and pin ownership
	// ----------------------------------------------------------------

	rpi_pkg::rpi_state_t state;
	rpi_pkg::rpi_state_t next_state;
	logic [7:0] settle_cnt;
	logic [7:0] next_settle_cnt;
	logic [7:0] win_cnt;
	logic [7:0] next_win_cnt;
	logic cmd_mode;
	logic next_cmd_mode;
	logic sampled;
	logic next_sampled;
	logic settle_end;

	assign settle_end = (state == rpi_pkg::RPI_SETTLE) &&
		(settle_cnt >= 8'(`RPI_SETTLE_CYCLES - 1));

	// Pin is an input until the window runs out, then a driven output while the setting is nonzero
	always_comb
	begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		next_win_cnt = win_cnt;
		next_cmd_mode = cmd_mode;
		next_sampled = sampled;
		case (state)
			rpi_pkg::RPI_SETTLE:
			begin
				next_settle_cnt = settle_cnt + 8'h01;
				if (settle_end)
				begin
					next_cmd_mode = ~CFG_PIN_IN; // Low pin asks for command mode
					next_sampled = 1'b1;
					next_win_cnt = hold_setting;
					if (hold_setting == `RPI_HOLD_RESET)
						next_state = rpi_pkg::RPI_IDLE;
					else
						next_state = rpi_pkg::RPI_WINDOW;
				end
			end
			rpi_pkg::RPI_WINDOW:
			begin
				if (hold_setting == `RPI_HOLD_RESET)
					next_state = rpi_pkg::RPI_IDLE;
				else if (win_cnt == 8'h00 || (tick && win_cnt == 8'h01))
					next_state = rpi_pkg::RPI_DRIVE; // Window of setting x 100 ms
				else if (tick)
					next_win_cnt = win_cnt - 8'h01;
			end
			rpi_pkg::RPI_DRIVE:
			begin
				if (hold_setting == `RPI_HOLD_RESET)
					next_state = rpi_pkg::RPI_IDLE; // Disabled: release the pin
			end
			rpi_pkg::RPI_IDLE:
			begin
				if (hold_setting != `RPI_HOLD_RESET)
					next_state = rpi_pkg::RPI_DRIVE; // Turned on later: output low first
			end
			default:
				next_state = rpi_pkg::RPI_SETTLE;
		endcase
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state <= rpi_pkg::RPI_SETTLE; // Pin input from power-up
			settle_cnt <= 8'h00;
			win_cnt <= 8'h00;
			cmd_mode <= 1'b0;
			sampled <= 1'b0;
		end
		else
		begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
			win_cnt <= next_win_cnt;
			cmd_mode <= next_cmd_mode;
			sampled <= next_sampled;
		end
	end

	assign CMD_MODE_SEL = cmd_mode;
	assign SAMPLE_DONE = sampled;

	// ----------------------------------------------------------------
	// Packet level and hold timer
	// ----------------------------------------------------------------

	logic active;
	logic next_active;
	logic [7:0] hold_cnt;
	logic [7:0] next_hold_cnt;
	logic [5:0] duty_pending;
	logic [5:0] next_duty_pending;

	assign tick_restart = PKT_VALID || settle_end;

	// A packet wins over an expiry landing in the same cycle
	always_comb
	begin
		next_active = active;
		next_hold_cnt = hold_cnt;
		next_duty_pending = duty_pending;
		if (PKT_VALID)
			next_duty_pending = duty_map(PKT_MARGIN); // Latest packet only
		if (hold_setting == `RPI_HOLD_RESET)
			next_active = 1'b0;
		else if (PKT_VALID)
		begin
			next_active = 1'b1; // Resume on next packet
			next_hold_cnt = hold_setting;
		end
		else if (active && hold_setting != `RPI_HOLD_FOREVER && tick)
		begin
			// Permanent code never counts down
			if (hold_cnt <= 8'h01)
				next_active = 1'b0; // Hold expired: force 0 percent
			else
				next_hold_cnt = hold_cnt - 8'h01;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			active <= 1'b0; // Low until first packet
			hold_cnt <= 8'h00;
			duty_pending <= 6'h00;
		end
		else
		begin
			active <= next_active;
			hold_cnt <= next_hold_cnt;
			duty_pending <= next_duty_pending;
		end
	end

	// ----------------------------------------------------------------
	// PWM frame and pin drive
	// ----------------------------------------------------------------

	logic [5:0] step_idx;
	logic frame_start;
	logic [5:0] duty_cur;
	logic [5:0] next_duty_cur;
	rpi_pkg::rpi_pin_drv_t pin;
	rpi_pkg::rpi_pin_drv_t next_pin;

	rpi_frame_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_frame (
		.clk(CLK),
		.rst(RST),
		.step_idx(step_idx),
		.frame_start(frame_start)
	);

	// Duty changes only between frames so no runt pulse appears; loss of
	// activity drops the pin at once rather than finishing the frame
	always_comb
	begin
		next_duty_cur = duty_cur;
		if (frame_start)
			next_duty_cur = duty_pending;
		next_pin.oe = (state == rpi_pkg::RPI_DRIVE);
		// Compare with the value taking effect this cycle so the first step of a
		// new frame already uses the new duty
		next_pin.out = (state == rpi_pkg::RPI_DRIVE) && active &&
			(step_idx < next_duty_cur);
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			duty_cur <= 6'h00;
			pin <= '0;
		end
		else
		begin
			duty_cur <= next_duty_cur;
			pin <= next_pin;
		end
	end

	assign CFG_PIN_OUT = pin.out;
	assign CFG_PIN_OE = pin.oe;

endmodule // rpi_top

// ===== rpi_top_asserts.sv
// Port-level assertions for the signal-strength PWM indicator.
`timescale 1ns/1ps
`include "rpi_params.svh"

module rpi_top_asserts #(
	parameter int unsigned STEP_CYCLES = 4
) (
	input logic CLK,
	input logic RST,
	input rpi_pkg::rpi_cmd_req_t CMD_REQ,
	input rpi_pkg::rpi_cmd_rsp_t CMD_RSP,
	input logic PKT_VALID,
	input logic CFG_PIN_OUT,
	input logic CFG_PIN_OE,
	input logic SAMPLE_DONE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic seen;
	logic [31:0] hi_cnt;
	wire hold_wr = CMD_REQ.valid && CMD_REQ.write && CMD_REQ.code == `RPI_CODE_HOLD;
	wire bad_val = CMD_REQ.wdata > `RPI_HOLD_MAX && CMD_REQ.wdata != `RPI_HOLD_FOREVER;
	wire bad_code = CMD_REQ.valid && CMD_REQ.code != `RPI_CODE_HOLD;

	// Packet seen since reset; length of the current high run
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			seen <= 1'b0;
			hi_cnt <= 32'h0000_0000;
		end
		else
		begin
			seen <= seen | PKT_VALID;
			// Wide enough for the full-length top step, so it never wraps
			hi_cnt <= CFG_PIN_OUT ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// Counting the run catches a top step of 39 that a per-cycle check would miss
	a_ack_next_cycle: assert property (CMD_REQ.valid |=> CMD_RSP.ack)
		else $error("command not answered next cycle");
	a_bad_code_err: assert property (bad_code |=> CMD_RSP.err)
		else $error("unknown code not refused");
	a_range_err: assert property (hold_wr && bad_val |=> CMD_RSP.err)
		else $error("out of range hold time accepted");
	a_good_write_ok: assert property (hold_wr && !bad_val |=> !CMD_RSP.err)
		else $error("legal hold time refused");
	a_out_needs_oe: assert property (CFG_PIN_OUT |-> CFG_PIN_OE)
		else $error("pin high while not driven");
	a_input_at_power: assert property (!SAMPLE_DONE |-> !CFG_PIN_OE)
		else $error("pin driven before power-up sample");
	a_low_before_pkt: assert property (!seen |-> !CFG_PIN_OUT)
		else $error("pin high before any packet");
	a_high_run_bound: assert property (hi_cnt <= `RPI_DUTY_MAX * STEP_CYCLES)
		else $error("high time above top step");
	c_ack: cover property (CMD_RSP.ack);
	c_pwm_high: cover property ($rose(CFG_PIN_OUT));
	c_drive: cover property ($rose(CFG_PIN_OE));
endmodule // rpi_top_asserts

bind rpi_top rpi_top_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_asserts (
	.CLK(CLK),
	.RST(RST),
	.CMD_REQ(CMD_REQ),
	.CMD_RSP(CMD_RSP),
	.PKT_VALID(PKT_VALID),
	.CFG_PIN_OUT(CFG_PIN_OUT),
	.CFG_PIN_OE(CFG_PIN_OE),
	.SAMPLE_DONE(SAMPLE_DONE)
);

// ===== test_rssi_pwm_indicator.sv
// Self-checking bench for the signal-strength PWM indicator.
`timescale 1ns/1ps
`include "rpi_params.svh"

module test_rssi_pwm_indicator;
	localparam int STEP = 4;
	localparam int TICK = 50;
	localparam int FRAME = 40 * STEP;
	logic clk;
	logic rst;
	rpi_pkg::rpi_cmd_req_t cmd_req;
	rpi_pkg::rpi_cmd_rsp_t cmd_rsp;
	logic pkt_valid;
	logic [7:0] pkt_margin;
	logic pin_in;
	logic pin_out;
	logic pin_oe;
	logic mode_sel;
	logic sample_done;
	logic strap_low;
	int n_mismatch;
	int total_checks;
	logic [15:0] n_high;

	rpi_top #(.STEP_CYCLES(STEP), .TICK_CYCLES(TICK)) u_dut (
		.CLK(clk),
		.RST(rst),
		.CMD_REQ(cmd_req),
		.CMD_RSP(cmd_rsp),
		.PKT_VALID(pkt_valid),
		.PKT_MARGIN(pkt_margin),
		.CFG_PIN_IN(pin_in),
		.CFG_PIN_OUT(pin_out),
		.CFG_PIN_OE(pin_oe),
		.CMD_MODE_SEL(mode_sel),
		.SAMPLE_DONE(sample_done)
	);

	rpi_pin_model u_pin (
		.strap_low(strap_low),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_level(pin_in)
	);

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One command; rdata is only defined for reads
	task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] wd,
		input logic [7:0] exp_rd, input logic exp_err);
		@(posedge clk);
		cmd_req <= '{1'b1, wr, code, wd};
		@(posedge clk);
		cmd_req.valid <= 1'b0;
		#1;
		check({cmd_rsp.ack, cmd_rsp.err}, {1'b1, exp_err});
		if (!wr)
			check(cmd_rsp.rdata, exp_rd);
	endtask

	task automatic pkt(input logic [7:0] m);
		@(posedge clk);
		pkt_valid <= 1'b1;
		pkt_margin <= m;
		@(posedge clk);
		pkt_valid <= 1'b0;
	endtask

	// Any whole frame holds exactly the duty's high cycles
	task automatic count_high(input int cycles);
		n_high = 16'h0000;
		repeat (cycles)
		begin
			@(posedge clk);
			#1;
			// Four-state sum: an unknown pin level poisons the count
			n_high = n_high + {15'h0000, pin_out};
		end
	endtask

	// Bounded wait on sample_done (sel 0) or pin_oe (sel 1)
	task automatic wait_flag(input logic sel, input int bound);
		int i;
		for (i = 0; i < bound && (sel ? pin_oe : sample_done) !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (i == bound)
		begin
			n_mismatch++;
			final_report();
		end
	endtask

	task automatic t_power_up();
		cmd(1'b1, `RPI_CODE_HOLD, 8'h02, 8'h00, 1'b0);
		wait_flag(1'b0, 40);
		check(mode_sel, 1'b1);
		check(pin_oe, 1'b0);
		@(posedge clk);
		strap_low <= 1'b0;
		repeat (2 * TICK - 10) @(posedge clk);
		#1;
		check(pin_oe, 1'b0);
		wait_flag(1'b1, 40);
		count_high(FRAME);
		check(n_high, 16'h0000);
		$display("end power_up");
	endtask

	task automatic t_commands();
		cmd(1'b0, `RPI_CODE_HOLD, 8'h00, 8'h02, 1'b0);
		cmd(1'b1, 8'h21, 8'h05, 8'h00, 1'b1);
		cmd(1'b1, `RPI_CODE_HOLD, 8'h80, 8'h00, 1'b1);
		cmd(1'b1, `RPI_CODE_HOLD, 8'hFE, 8'h00, 1'b1);
		cmd(1'b1, `RPI_CODE_HOLD, 8'h7F, 8'h00, 1'b0);
		cmd(1'b0, `RPI_CODE_HOLD, 8'h00, 8'h7F, 1'b0);
		cmd(1'b1, `RPI_CODE_HOLD, 8'hFF, 8'h00, 1'b0);
		$display("end commands");
	endtask

	task automatic t_duty();
		logic [7:0] mg [6] = '{8'h0A, 8'h14, 8'h1E, 8'h00, 8'h2A, 8'hC8};
		int st [6] = '{19, 25, 31, 0, 38, 38};
		for (int k = 0; k < 6; k++)
		begin
			pkt(mg[k]);
			repeat (2 * FRAME) @(posedge clk);
			count_high(FRAME);
			check(n_high, 16'(st[k] * STEP));
		end
		repeat (13000) @(posedge clk);
		count_high(FRAME);
		check(n_high, 16'(38 * STEP));
		$display("end duty");
	endtask

	task automatic t_hold();
		cmd(1'b1, `RPI_CODE_HOLD, 8'h07, 8'h00, 1'b0);
		pkt(8'h1E);
		repeat (FRAME + 10) @(posedge clk);
		count_high(FRAME);
		check(n_high, 16'(31 * STEP));
		pkt(8'h1E);
		count_high(FRAME);
		check(n_high, 16'(31 * STEP));
		repeat (250) @(posedge clk);
		count_high(FRAME);
		check({pin_oe, n_high[14:0]}, 16'h8000);
		pkt(8'h0A);
		repeat (FRAME + 10) @(posedge clk);
		count_high(FRAME);
		check(n_high, 16'(19 * STEP));
		$display("end hold");
	endtask

	task automatic t_disable();
		cmd(1'b1, `RPI_CODE_HOLD, 8'h00, 8'h00, 1'b0);
		pkt(8'h1E);
		count_high(2 * FRAME);
		check({pin_oe, n_high[14:0]}, 16'h0000);
		$display("end disable");
	endtask

	// Second power-up with the pin pulled high and the setting at its default
	task automatic t_reset();
		@(posedge clk);
		rst <= 1'b1;
		strap_low <= 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check({pin_oe, sample_done, mode_sel}, 3'b000);
		wait_flag(1'b0, 40);
		check(mode_sel, 1'b0);
		cmd(1'b0, `RPI_CODE_HOLD, 8'h00, `RPI_HOLD_RESET, 1'b0);
		repeat (3 * TICK) @(posedge clk);
		#1;
		check(pin_oe, 1'b0);
		$display("end reset");
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		cmd_req = '0;
		pkt_valid = 1'b0;
		pkt_margin = 8'h00;
		strap_low = 1'b1;
		n_mismatch = 0;
		total_checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_power_up();
		t_commands();
		t_duty();
		t_hold();
		t_disable();
		t_reset();
		final_report();
	end
endmodule // test_rssi_pwm_indicator
